// ### logic/slcg_map.svh
// Purpose: offsets, field positions and reset values of the sleep gating block
// Assumes: byte offsets on a 12-bit register port, 32-bit data
// Notes:   definitions only
`ifndef SLCG_MAP_SVH
`define SLCG_MAP_SVH

`define SLCG_ADDR_W          12
`define SLCG_DATA_W          32
`define SLCG_NUM_UNITS       5

// register offsets
`define SLCG_SLEEP_GATE_OFS  12'h110
`define SLCG_STATUS_OFS      12'h114

// sleep_clock_gate_ctrl0 layout
`define SLCG_SLEEP_GATE_RST  32'h0000_0040
`define SLCG_RW_MASK         32'h0310_0048
`define SLCG_BIT_CAN_B       25
`define SLCG_BIT_CAN_A       24
`define SLCG_BIT_PWM         20
`define SLCG_BIT_HIB         6
`define SLCG_BIT_WDT         3

// unit index inside the enable vectors
`define SLCG_U_WDT           0
`define SLCG_U_HIB           1
`define SLCG_U_PWM           2
`define SLCG_U_CAN_A         3
`define SLCG_U_CAN_B         4

// status register layout
`define SLCG_ST_EN_LSB       0
`define SLCG_ST_MODE_LSB     8
`define SLCG_ST_AGS_BIT      10

`endif

// ### logic/slcg_pkg.sv
// Purpose: types shared by the sleep gating block
// Assumes: nothing
// Notes:   mode codes are gray along run, sleep, deep sleep
`default_nettype none
package slcg_pkg;
    typedef enum logic [1:0] {
        SLCG_RUN   = 2'h0,
        SLCG_SLEEP = 2'h1,
        SLCG_DEEP  = 2'h3
    } slcg_mode_t;

    typedef logic [4:0] slcg_units_t;
endpackage
`default_nettype wire

// ### logic/slcg_ctrl.sv
// Purpose: sleep-mode clock gating register and unit clock gates
// Assumes: mode, companion gating and access-request inputs come from clk logic
// Notes:   unit order in vectors is wdt, hib, pwm, can_a, can_b (bit 0 up)
//
// How it works
// R1 - A set gating bit clocks its unit and a clear one stops and disables it.
// R2 - An access to a unit whose clock is off ends in a bus fault.
// R3 - Reset clears every gating bit except the documented exception.
// R4 - The sleep gating register is a 32-bit word at 0x110 resetting to 0x00000040.
// R5 - Bit 25 is a read/write enable for the second CAN unit, reset zero.
// R6 - Bit 24 is a read/write enable for the first CAN unit, reset zero.
// R7 - Bit 20 gates the PWM module, resets zero, and PWM access while off faults.
// R8 - Bit 6 gates the hibernation module and resets to one.
// R9 - Bit 3 gates the watchdog, resets zero, and watchdog access while off faults.
// R10 - Reserved bits read zero, ignore writes, and software preserves them.
// R11 - This register rules the unit clocks only in sleep with auto gating set.
// R12 - Each unit clock is gated glitch free by a latch open while clk is low.
`timescale 1ns/1ns
`include "slcg_map.svh"
`default_nettype none

module slcg_ctrl
    import slcg_pkg::*;
(
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    // register port
    input  wire logic [`SLCG_ADDR_W-1:0]   reg_addr,
    input  wire logic [`SLCG_DATA_W-1:0]   reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [`SLCG_DATA_W-1:0]   reg_rdata,
    // power mode and companion gating
    input  wire logic                      sleep_mode,
    input  wire logic                      deep_sleep_mode,
    input  wire logic                      auto_gating_select,
    input  wire logic [4:0]                run_clock_gate_ctrl0,
    input  wire logic [4:0]                deep_sleep_clock_gate_ctrl0,
    // unit access checking
    input  wire logic [4:0]                unit_access_req,
    output logic      [4:0]                unit_bus_fault,
    // unit clocks
    output logic      [4:0]                unit_clk_en,
    output logic      [4:0]                unit_clk
);

    // pick the five gating bits out of a register word
    function automatic slcg_units_t units_of(input logic [`SLCG_DATA_W-1:0] w);
        slcg_units_t u;
        u = '0;
        u[`SLCG_U_WDT]   = w[`SLCG_BIT_WDT];
        u[`SLCG_U_HIB]   = w[`SLCG_BIT_HIB];
        u[`SLCG_U_PWM]   = w[`SLCG_BIT_PWM];
        u[`SLCG_U_CAN_A] = w[`SLCG_BIT_CAN_A];
        u[`SLCG_U_CAN_B] = w[`SLCG_BIT_CAN_B];
        return u;
    endfunction

    // place the five gating bits back at their word positions
    function automatic logic [`SLCG_DATA_W-1:0] word_of(input slcg_units_t u);
        logic [`SLCG_DATA_W-1:0] w;
        w = '0;
        w[`SLCG_BIT_WDT]   = u[`SLCG_U_WDT];
        w[`SLCG_BIT_HIB]   = u[`SLCG_U_HIB];
        w[`SLCG_BIT_PWM]   = u[`SLCG_U_PWM];
        w[`SLCG_BIT_CAN_A] = u[`SLCG_U_CAN_A];
        w[`SLCG_BIT_CAN_B] = u[`SLCG_U_CAN_B];
        return w;
    endfunction

    // sleep gating register
    slcg_units_t                 gate_r;
    slcg_units_t                 gate_nxt;
    // power mode tracker
    slcg_mode_t                  mode_r;
    slcg_mode_t                  mode_nxt;
    logic                        ags_r;
    // gating result and fault flags
    slcg_units_t                 en_r;
    slcg_units_t                 en_nxt;
    slcg_units_t                 fault_r;
    slcg_units_t                 fault_nxt;
    // read path
    logic [`SLCG_DATA_W-1:0]     rdata_r;
    logic [`SLCG_DATA_W-1:0]     rdata_nxt;
    // glitch-free gate latches
    slcg_units_t                 en_lat;
    // mode selection result
    slcg_units_t                 sel_en_c;

    // register decode
    wire logic                   hit_gate;
    wire logic                   hit_status;
    wire logic                   gate_wr;
    wire logic [`SLCG_DATA_W-1:0] gate_word;
    wire logic [`SLCG_DATA_W-1:0] status_word;
    wire logic [`SLCG_DATA_W-1:0] read_mux;
    wire slcg_units_t            sel_en;
    wire logic                   sleep_rules;

    assign hit_gate   = (reg_addr == `SLCG_SLEEP_GATE_OFS); // R4
    assign hit_status = (reg_addr == `SLCG_STATUS_OFS);
    assign gate_wr    = reg_wr && hit_gate;

    // reserved bits are simply not stored, so they always read back zero
    assign gate_word  = word_of(gate_r) & `SLCG_RW_MASK; // R10

    assign status_word = {21'h0, ags_r, mode_r,
                          3'h0, en_r};

    // unmapped offsets read as zero and ignore writes
    assign read_mux = hit_gate   ? gate_word   :
                      hit_status ? status_word :
                                   32'h0000_0000;

    assign gate_nxt  = gate_wr ? units_of(reg_wdata) : gate_r; // R5 R6 R7 R8 R9
    assign rdata_nxt = reg_rd ? read_mux : 32'h0000_0000;

    // mode tracking: deep sleep outranks sleep
    assign mode_nxt = deep_sleep_mode ? SLCG_DEEP  :
                      sleep_mode      ? SLCG_SLEEP :
                                        SLCG_RUN;

    // without auto gating the run register keeps ruling in every state
    assign sleep_rules = ags_r && (mode_r == SLCG_SLEEP); // R11

    always_comb begin
        case (mode_r)
            SLCG_SLEEP: sel_en_c = ags_r ? gate_r : run_clock_gate_ctrl0;
            SLCG_DEEP:  sel_en_c = ags_r ? deep_sleep_clock_gate_ctrl0
                                         : run_clock_gate_ctrl0;
            SLCG_RUN:   sel_en_c = run_clock_gate_ctrl0;
            default:    sel_en_c = run_clock_gate_ctrl0;
        endcase
    end

    assign sel_en = sel_en_c; // R11

    assign en_nxt = sel_en; // R1

    // a unit with no clock cannot answer, so the access is faulted instead
    assign fault_nxt = unit_access_req & ~en_r; // R2 R7 R9

    // storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gate_r <= units_of(`SLCG_SLEEP_GATE_RST); // R3 R4 R8
        end else begin
            gate_r <= gate_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= SLCG_RUN;
            ags_r  <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            ags_r  <= auto_gating_select;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            en_r <= units_of(`SLCG_SLEEP_GATE_RST); // R3
        end else begin
            en_r <= en_nxt; // R1
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_r <= '0;
        end else begin
            fault_r <= fault_nxt; // R2
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // latch is transparent only while clk is low, so the and-gate never
    // sees an enable edge during the high phase
    always_latch begin
        if (!clk) begin
            en_lat <= en_r; // R12
        end
    end

    assign unit_clk       = {5{clk}} & en_lat; // R12 R1
    assign unit_clk_en    = en_r;
    assign unit_bus_fault = fault_r;
    assign reg_rdata      = rdata_r;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic first_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            first_r <= 1'b1;
        end else begin
            first_r <= 1'b0;
        end
    end

    sequence s_gate_write;
        reg_wr && (reg_addr == `SLCG_SLEEP_GATE_OFS);
    endsequence

    sequence s_gate_read;
        reg_rd && (reg_addr == `SLCG_SLEEP_GATE_OFS);
    endsequence

    sequence s_sleep_auto;
        sleep_rules && !reg_wr;
    endsequence

    sequence s_status_read;
        reg_rd && (reg_addr == `SLCG_STATUS_OFS);
    endsequence

    a_reset_value: assert property ( // R3
        first_r |-> (gate_r == units_of(`SLCG_SLEEP_GATE_RST))
                    && (en_r == 5'h02))
        else $error("gating bits wrong after reset");

    a_gate_offset: assert property ( // R4
        s_gate_read |=> reg_rdata == $past({6'h00, gate_r[4], gate_r[3], 3'h0,
                                            gate_r[2], 13'h0000, gate_r[1],
                                            2'h0, gate_r[0], 3'h0}))
        else $error("register read at gate offset wrong");

    a_can_b_bit: assert property ( // R5
        s_gate_write ##1 reg_rd && hit_gate && !reg_wr
        |=> reg_rdata[`SLCG_BIT_CAN_B] == $past(reg_wdata[`SLCG_BIT_CAN_B], 2))
        else $error("can b enable not stored");

    a_can_a_bit: assert property ( // R6
        s_gate_write |=> gate_r[`SLCG_U_CAN_A] == $past(reg_wdata[`SLCG_BIT_CAN_A]))
        else $error("can a enable not stored");

    a_pwm_fault: assert property ( // R7
        unit_access_req[`SLCG_U_PWM] && !en_r[`SLCG_U_PWM]
        |=> unit_bus_fault[`SLCG_U_PWM])
        else $error("pwm access while gated did not fault");

    a_hib_bit: assert property ( // R8
        s_gate_write |=> gate_r[`SLCG_U_HIB] == $past(reg_wdata[`SLCG_BIT_HIB]))
        else $error("hibernate enable not stored");

    a_wdt_fault: assert property ( // R9
        unit_access_req[`SLCG_U_WDT] && !en_r[`SLCG_U_WDT]
        |=> unit_bus_fault[`SLCG_U_WDT] ##0 !$past(unit_clk_en[`SLCG_U_WDT]))
        else $error("watchdog access while gated did not fault");

    a_reserved_zero: assert property ( // R10
        s_gate_read |=> (reg_rdata & ~`SLCG_RW_MASK) == 32'h0000_0000)
        else $error("reserved bits read nonzero");

    a_sleep_rules: assert property ( // R11
        s_sleep_auto ##1 s_sleep_auto |-> unit_clk_en == $past(gate_r))
        else $error("sleep gating not applied in sleep");

    a_run_ignores: assert property ( // R11
        (mode_r == SLCG_RUN) |=> unit_clk_en == $past(run_clock_gate_ctrl0))
        else $error("run gating not applied in run");

    a_fault_any: assert property ( // R2
        (unit_access_req & en_r) == unit_access_req |=> unit_bus_fault == 5'h00)
        else $error("fault raised on clocked unit");

    a_gate_follow: assert property ( // R1
        $changed(sel_en) |=> unit_clk_en == $past(sel_en) [*1] ##1 1'b1)
        else $error("enable did not follow selection");

    a_read_once: assert property ( // R4
        !reg_rd |=> reg_rdata == 32'h0000_0000)
        else $error("read data held past its cycle");

    a_rd_unmapped: assert property ( // R4
        reg_rd && (reg_addr != `SLCG_SLEEP_GATE_OFS) && (reg_addr != `SLCG_STATUS_OFS)
        |=> reg_rdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    a_write_ignored: assert property ( // R4
        reg_wr && (reg_addr != `SLCG_SLEEP_GATE_OFS) |=> $stable(gate_r))
        else $error("write elsewhere changed gating bits");

    a_gate_hold: assert property ( // R10
        !reg_wr |=> $stable(gate_r))
        else $error("gating bits changed without a write");

    // status layout is a local choice, checked field by field except the mode bits 9:8
    a_status_read: assert property ( // R11
        s_status_read |=> (reg_rdata[4:0] == $past(unit_clk_en))
                          && (reg_rdata[10] == $past(auto_gating_select, 2))
                          && (reg_rdata[31:11] == 21'h0)
                          && (reg_rdata[7:5] == 3'h0))
        else $error("status word wrong");

    a_mode_sleep: assert property ( // R11
        sleep_mode && !deep_sleep_mode |=> mode_r == SLCG_SLEEP)
        else $error("sleep not tracked");

    a_mode_deep: assert property ( // R11
        deep_sleep_mode |=> mode_r == SLCG_DEEP)
        else $error("deep sleep not tracked");

    a_deep_select: assert property ( // R11
        ags_r && (mode_r == SLCG_DEEP) |=> unit_clk_en == $past(deep_sleep_clock_gate_ctrl0))
        else $error("deep sleep gating not applied");

    a_no_auto: assert property ( // R11
        !ags_r && (mode_r != SLCG_RUN) |=> unit_clk_en == $past(run_clock_gate_ctrl0))
        else $error("run gating not kept without auto gating");

    a_fault_idle: assert property ( // R2
        unit_access_req == 5'h00 |=> unit_bus_fault == 5'h00)
        else $error("fault without an access");

    // faults cover every unit, not only pwm and watchdog
    a_hib_fault: assert property ( // R2
        unit_access_req[`SLCG_U_HIB] && !en_r[`SLCG_U_HIB]
        |=> unit_bus_fault[`SLCG_U_HIB])
        else $error("hibernate access while gated did not fault");

    a_can_fault: assert property ( // R2
        unit_access_req[`SLCG_U_CAN_B] && !en_r[`SLCG_U_CAN_B]
        |=> unit_bus_fault[`SLCG_U_CAN_B])
        else $error("can b access while gated did not fault");

    // the latch must have caught the flop value by each rising edge
    a_latch_follow: assert property ( // R12
        en_lat == en_r)
        else $error("gate latch lags the enable");

endmodule

`default_nettype wire

// ### bench/tb_top.sv
// Purpose: self-checking bench for the sleep gating register and unit gates
// Assumes: register port answers one cycle after a read strobe
// Notes:   unit vectors ordered wdt, hib, pwm, can_a, can_b from bit 0
`timescale 1ns/1ns
`include "slcg_map.svh"
`default_nettype none

module tb_top import slcg_pkg::*;;
    // clock and reset
    logic                    clk;
    logic                    rst_n;
    // register port
    logic [`SLCG_ADDR_W-1:0] reg_addr;
    logic [`SLCG_DATA_W-1:0] reg_wdata;
    logic                    reg_wr;
    logic                    reg_rd;
    logic [`SLCG_DATA_W-1:0] reg_rdata;
    // mode and companions
    logic                    sleep_mode;
    logic                    deep_sleep_mode;
    logic                    auto_gating_select;
    slcg_units_t             run_vec;
    slcg_units_t             deep_vec;
    // unit side
    slcg_units_t             unit_access_req;
    slcg_units_t             unit_bus_fault;
    slcg_units_t             unit_clk_en;
    slcg_units_t             unit_clk;
    int                      miscompares;
    int                      tests_run;
    logic [31:0]             rd_val;

    slcg_ctrl i_slcg_ctrl (
        .clk                         (clk),
        .rst_n                       (rst_n),
        .reg_addr                    (reg_addr),
        .reg_wdata                   (reg_wdata),
        .reg_wr                      (reg_wr),
        .reg_rd                      (reg_rd),
        .reg_rdata                   (reg_rdata),
        .sleep_mode                  (sleep_mode),
        .deep_sleep_mode             (deep_sleep_mode),
        .auto_gating_select          (auto_gating_select),
        .run_clock_gate_ctrl0        (run_vec),
        .deep_sleep_clock_gate_ctrl0 (deep_vec),
        .unit_access_req             (unit_access_req),
        .unit_bus_fault              (unit_bus_fault),
        .unit_clk_en                 (unit_clk_en),
        .unit_clk                    (unit_clk)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // data stands only in the cycle after the read edge
    task automatic reg_read(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // write then read with no idle cycle between the strobes
    task automatic reg_write_read(input logic [11:0] a, input logic [31:0] wd,
                                  output logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= wd;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic set_mode(input logic slp, input logic dp, input logic ags);
        @(posedge clk);
        sleep_mode         <= slp;
        deep_sleep_mode    <= dp;
        auto_gating_select <= ags;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic test_reset_and_fields();
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        check(rd_val, 32'h0000_0040, "reset word");
        check({27'h0, unit_clk_en}, 32'h0000_0000, "run enables after reset");
        reg_write(`SLCG_SLEEP_GATE_OFS, 32'hffff_ffff);
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        check(rd_val, 32'h0310_0048, "writable bits only");
        reg_write(`SLCG_SLEEP_GATE_OFS, 32'h0000_0000);
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        check(rd_val, 32'h0000_0000, "hib clears by write");
        reg_write(12'h200, 32'hffff_ffff);
        reg_read(12'h200, rd_val);
        check(rd_val, 32'h0000_0000, "unmapped reads zero");
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        check(rd_val, 32'h0000_0000, "unmapped write ignored");
    endtask

    task automatic test_selection();
        // can_a, pwm, wdt set: units 3, 2, 0
        reg_write(`SLCG_SLEEP_GATE_OFS, 32'h0110_0008);
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        check(rd_val, 32'h0110_0008, "bits 24 20 3 held");
        set_mode(1'b1, 1'b0, 1'b1);
        check({27'h0, unit_clk_en}, 32'h0000_000d, "sleep uses register");
        reg_read(`SLCG_STATUS_OFS, rd_val);
        check(rd_val, 32'h0000_050d, "status in sleep with auto");
        set_mode(1'b1, 1'b0, 1'b0);
        check({27'h0, unit_clk_en}, 32'h0000_0012, "no auto keeps run");
        set_mode(1'b0, 1'b1, 1'b1);
        check({27'h0, unit_clk_en}, 32'h0000_0005, "deep uses companion");
        reg_write_read(`SLCG_SLEEP_GATE_OFS, 32'h0200_0000, rd_val);
        check(rd_val, 32'h0200_0000, "can_b read back at once");
        set_mode(1'b1, 1'b0, 1'b1);
        check({27'h0, unit_clk_en}, 32'h0000_0010, "can_b only on");
    endtask

    task automatic test_faults_and_clocks();
        reg_write(`SLCG_SLEEP_GATE_OFS, 32'h0110_0008);
        repeat (3) @(posedge clk);
        @(posedge clk);
        unit_access_req <= 5'h1f;
        @(posedge clk);
        unit_access_req <= 5'h05;
        #1;
        check({27'h0, unit_bus_fault}, 32'h0000_0012, "faults on gated units");
        @(posedge clk);
        unit_access_req <= 5'h00;
        #1;
        check({27'h0, unit_bus_fault}, 32'h0000_0000, "clocked units no fault");
        @(posedge clk);
        #1;
        check({27'h0, unit_bus_fault}, 32'h0000_0000, "fault one cycle");
        #10;
        check({27'h0, unit_clk}, 32'h0000_000d, "high phase gated");
        @(negedge clk);
        #10;
        check({27'h0, unit_clk}, 32'h0000_0000, "low phase quiet");
        // read-modify-write: drop can_a, pwm, wdt, keep reserved bits, set hib
        reg_read(`SLCG_SLEEP_GATE_OFS, rd_val);
        reg_write(`SLCG_SLEEP_GATE_OFS, (rd_val & 32'hfeef_fff7) | 32'h0000_0040);
        repeat (2) @(posedge clk);
        unit_access_req <= 5'h05;
        @(posedge clk);
        unit_access_req <= 5'h00;
        #1;
        check({31'h0, unit_bus_fault[`SLCG_U_PWM]}, 32'h0000_0001, "pwm gated faults");
        check({31'h0, unit_bus_fault[`SLCG_U_WDT]}, 32'h0000_0001, "wdt gated faults");
        #10;
        check({27'h0, unit_clk}, 32'h0000_0002, "only hib clocked");
    endtask

    initial begin
        #100000;
        miscompares++;
        close_out();
    end

    initial begin
        miscompares        = 0;
        tests_run          = 0;
        rst_n              = 1'b0;
        reg_addr           = '0;
        reg_wdata          = '0;
        reg_wr             = 1'b0;
        reg_rd             = 1'b0;
        sleep_mode         = 1'b0;
        deep_sleep_mode    = 1'b0;
        auto_gating_select = 1'b0;
        run_vec            = 5'h12;
        deep_vec           = 5'h05;
        unit_access_req    = 5'h00;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        check({27'h0, unit_clk_en}, 32'h0000_0002, "hib only in reset");
        run_vec <= 5'h00;
        test_reset_and_fields();
        @(posedge clk);
        run_vec <= 5'h12;
        test_selection();
        test_faults_and_clocks();
        close_out();
    end
endmodule
`default_nettype wire
